// *** mifl_change_det.sv ***
// change and rising-edge detector for a vector of same-clock levels
`timescale 1ns/1ps
`include "mifl_defs.svh"
module mifl_change_det #(
  parameter int W = 15
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // levels in
  input wire logic [W-1:0] level,
  // events out
  mifl_lvl_if.src ev
);
  logic [W-1:0] prev;
  logic primed;
  logic [W-1:0] next_prev;
  logic next_primed;

  always_comb begin
    next_prev = level;
    next_primed = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev <= '0;
      primed <= 1'b0;
    end else begin
      prev <= next_prev;
      primed <= next_primed;
    end
  end

  // no event before the first sample, so a level high at reset is not an edge
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign ev.chg[i] = primed & (level[i] ^ prev[i]);
      assign ev.rise[i] = primed & level[i] & ~prev[i];
    end
  endgenerate
endmodule : mifl_change_det

// *** mifl_defs.svh ***
// register map, flag positions and reset values of the metering interrupt flags
`ifndef MIFL_DEFS_SVH
`define MIFL_DEFS_SVH

`define MIFL_NFLAGS 20
`define MIFL_DATA_W 32
`define MIFL_ADDR_W 8
`define MIFL_BE_W 4
`define MIFL_IDX_LSB 2
`define MIFL_IDX_W 6
`define MIFL_NPH 3

`define MIFL_IDX_MASK 6'h18
`define MIFL_IDX_STATUS 6'h19
`define MIFL_IDX_CLEAR_ON_READ 6'h1a

`define MIFL_B_ACTIVE_ENERGY_HALF 0
`define MIFL_B_REACTIVE_ENERGY_HALF 1
`define MIFL_B_APPARENT_ENERGY_HALF 2
`define MIFL_B_SAG 3
`define MIFL_B_TIMEOUT 6
`define MIFL_B_CROSS 9
`define MIFL_B_LINE_ACCUM_DONE 12
`define MIFL_B_RESET 13
`define MIFL_B_PEAK_VOLTAGE 14
`define MIFL_B_PEAK_CURRENT 15
`define MIFL_B_WAVEFORM_SAMPLE 16
`define MIFL_B_ACTIVE_POWER_SIGN 17
`define MIFL_B_REACTIVE_POWER_SIGN 18
`define MIFL_B_PHASE_SEQUENCE_ERROR 19

`define MIFL_FLAGS_RESET 20'h02000
`define MIFL_FLAGS_ZERO 20'h00000
`define MIFL_MASK_RESET 20'h00000
`define MIFL_MASK_WRITABLE 20'hfdfff

`define MIFL_PH_A 0
`define MIFL_PH_B 1
`define MIFL_PH_C 2

`define MIFL_LV_W 15
`define MIFL_LV_ACT 0
`define MIFL_LV_REACT 3
`define MIFL_LV_APP 6
`define MIFL_LV_PSIGN 9
`define MIFL_LV_QSIGN 12

`endif

// *** mifl_host_model.sv ***
// host microcontroller model: avalon-mm master and interrupt service
`timescale 1ns/1ps
`include "mifl_defs.svh"
module mifl_host_model (
  // clock
  input wire logic clk_sys,
  // avalon-mm master
  output logic [`MIFL_ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [`MIFL_DATA_W-1:0] avs_writedata,
  output logic [`MIFL_BE_W-1:0] avs_byteenable,
  input wire logic [`MIFL_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // interrupt pin
  input wire logic irq_n_out
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // one transfer, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  // source first, then the clearing read
  task automatic service(output logic [31:0] st, output logic [31:0] rs);
    acc(1'b0, `MIFL_IDX_STATUS, 32'h0, 4'hf, st);
    acc(1'b0, `MIFL_IDX_CLEAR_ON_READ, 32'h0, 4'hf, rs);
  endtask : service
endmodule : mifl_host_model

// *** mifl_lvl_if.sv ***
// level-change events passed from the change detector to the flag logic
`timescale 1ns/1ps
interface mifl_lvl_if #(parameter int W = 15);
  logic [W-1:0] chg;
  logic [W-1:0] rise;
  modport src (output chg, output rise);
  modport dst (input chg, input rise);
endinterface : mifl_lvl_if

// *** mifl_pkg.sv ***
// types shared by the metering interrupt flag modules
`include "mifl_defs.svh"
package mifl_pkg;
  typedef logic [`MIFL_NFLAGS-1:0] mifl_flags_t;
  typedef enum logic [1:0] {
    MIFL_SEQ_IDLE = 2'b00,
    MIFL_SEQ_AFTER_A = 2'b01
  } mifl_seq_t;
endpackage : mifl_pkg

// *** mifl_top.sv ***
// sticky event flags, event mask, clear-on-read status and interrupt pin
`timescale 1ns/1ps
`include "mifl_defs.svh"
// Functional notes
// R1: each monitored event sets its flag bit in the event status register.
// R2: interrupt pin driven low when a set flag has its mask bit one.
// R3: flags stay set after the event until the clear mechanism clears them.
// R4: reading the clear-on-read register returns flags then returns them to defaults.
// R5: host first reads the status register to find the interrupt source.
// R6: bits 0 and 1 set when bit 14 changes in any active/reactive accumulator.
// R7: bit 2 set on a rising bit 15 of any apparent accumulator.
// R8: bits 3 to 5 flag voltage sag on phases A, B, C.
// R9: bits 6 to 8 flag missing zero crossing on phases A, B, C.
// R10: bits 9 to 11 flag rising zero crossing on phases A, B, C.
// R11: bit 12 flags end of line-cycle accumulation.
// R12: bit 13 defaults to one, marks reset, high for one clock only.
// R13: bits 14 and 15 flag voltage or current above peak threshold.
// R14: bit 16 flags a new waveform sample.
// R15: bits 17 and 18 flag power sign change on selected phases.
// R16: bit 19 flags phase A crossing followed next by phase B, not C.
// R17: interrupt pin released when the clear-on-read register is read.
// R18: mask holds one enable per flag, defaults zero, bit 13 reserved.
// R19: interrupt stays low while any enabled flag is set.
module mifl_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [`MIFL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`MIFL_DATA_W-1:0] avs_writedata,
  input wire logic [`MIFL_BE_W-1:0] avs_byteenable,
  output logic [`MIFL_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // energy accumulator bits, bit 0 is phase a
  input wire logic [`MIFL_NPH-1:0] active_accum_bit14,
  input wire logic [`MIFL_NPH-1:0] reactive_accum_bit14,
  input wire logic [`MIFL_NPH-1:0] apparent_accum_bit15,
  // detector pulses, bit 0 is phase a
  input wire logic [`MIFL_NPH-1:0] sag_event,
  input wire logic [`MIFL_NPH-1:0] timeout_event,
  input wire logic [`MIFL_NPH-1:0] crossing_event,
  input wire logic line_accum_done,
  input wire logic peak_voltage_event,
  input wire logic peak_current_event,
  input wire logic waveform_sample_event,
  input wire logic brownout_event,
  // power signs and phase selection
  input wire logic [`MIFL_NPH-1:0] active_power_sign,
  input wire logic [`MIFL_NPH-1:0] reactive_power_sign,
  input wire logic [`MIFL_NPH-1:0] phase_sum_select,
  // open-collector interrupt pin
  output logic irq_n_out,
  output logic irq_oe
);
  mifl_pkg::mifl_flags_t flags;
  mifl_pkg::mifl_flags_t mask;
  mifl_pkg::mifl_flags_t evt;
  mifl_pkg::mifl_flags_t next_flags;
  mifl_pkg::mifl_flags_t next_mask;
  mifl_pkg::mifl_flags_t be_bits;
  mifl_pkg::mifl_seq_t seq;
  mifl_pkg::mifl_seq_t next_seq;
  logic seq_err;
  logic wait_q;
  logic next_wait;
  logic [`MIFL_DATA_W-1:0] next_rdata;
  logic next_irq_n;
  logic next_irq_oe;
  logic req;
  logic accept;
  logic rc_accept;
  logic pend;
  logic [`MIFL_IDX_W-1:0] idx;

  mifl_lvl_if #(.W(`MIFL_LV_W)) lvl ();

  mifl_change_det #(.W(`MIFL_LV_W)) u_det (
    .clk_sys(clk_sys),
    .reset(reset),
    .level({reactive_power_sign, active_power_sign, apparent_accum_bit15,
            reactive_accum_bit14, active_accum_bit14}),
    .ev(lvl.src)
  );

  function automatic logic [`MIFL_IDX_W-1:0] reg_index(input logic [`MIFL_ADDR_W-1:0] a);
    reg_index = a[`MIFL_IDX_LSB +: `MIFL_IDX_W];
  endfunction : reg_index

  function automatic logic [`MIFL_DATA_W-1:0] pad(input mifl_pkg::mifl_flags_t v);
    pad = {{(`MIFL_DATA_W-`MIFL_NFLAGS){1'b0}}, v};
  endfunction : pad

  assign req = avs_read | avs_write;
  assign accept = req & ~wait_q;
  assign idx = reg_index(avs_address);
  assign rc_accept = accept & avs_read & (idx == `MIFL_IDX_CLEAR_ON_READ);
  assign pend = |(flags & mask & `MIFL_MASK_WRITABLE);

  // byte enables spread over the flag bits
  genvar b;
  generate
    for (b = 0; b < `MIFL_NFLAGS; b++) begin : g_be
      assign be_bits[b] = avs_byteenable[b / 8];
    end
  endgenerate

  // event collection
  always_comb begin
    evt = `MIFL_FLAGS_ZERO;
    evt[`MIFL_B_ACTIVE_ENERGY_HALF] = |lvl.chg[`MIFL_LV_ACT +: `MIFL_NPH]; // R6
    evt[`MIFL_B_REACTIVE_ENERGY_HALF] = |lvl.chg[`MIFL_LV_REACT +: `MIFL_NPH]; // R6
    evt[`MIFL_B_APPARENT_ENERGY_HALF] = |lvl.rise[`MIFL_LV_APP +: `MIFL_NPH]; // R7
    evt[`MIFL_B_SAG +: `MIFL_NPH] = sag_event; // R8
    evt[`MIFL_B_TIMEOUT +: `MIFL_NPH] = timeout_event; // R9
    evt[`MIFL_B_CROSS +: `MIFL_NPH] = crossing_event; // R10
    evt[`MIFL_B_LINE_ACCUM_DONE] = line_accum_done; // R11
    evt[`MIFL_B_PEAK_VOLTAGE] = peak_voltage_event; // R13
    evt[`MIFL_B_PEAK_CURRENT] = peak_current_event; // R13
    evt[`MIFL_B_WAVEFORM_SAMPLE] = waveform_sample_event; // R14
    evt[`MIFL_B_ACTIVE_POWER_SIGN] =
      |(lvl.chg[`MIFL_LV_PSIGN +: `MIFL_NPH] & phase_sum_select); // R15
    evt[`MIFL_B_REACTIVE_POWER_SIGN] =
      |(lvl.chg[`MIFL_LV_QSIGN +: `MIFL_NPH] & phase_sum_select); // R15
    evt[`MIFL_B_PHASE_SEQUENCE_ERROR] = seq_err; // R16
  end

  // phase order watch: after an a crossing the next must be c
  always_comb begin
    next_seq = seq;
    seq_err = 1'b0;
    unique case (seq)
      mifl_pkg::MIFL_SEQ_IDLE: begin
        if (crossing_event[`MIFL_PH_A]) begin
          next_seq = mifl_pkg::MIFL_SEQ_AFTER_A;
        end
      end
      mifl_pkg::MIFL_SEQ_AFTER_A: begin
        if (crossing_event[`MIFL_PH_B] & ~crossing_event[`MIFL_PH_C]) begin
          seq_err = 1'b1; // R16
        end
        if (crossing_event[`MIFL_PH_B] | crossing_event[`MIFL_PH_C]) begin
          next_seq = crossing_event[`MIFL_PH_A] ? mifl_pkg::MIFL_SEQ_AFTER_A
                                                : mifl_pkg::MIFL_SEQ_IDLE;
        end
      end
      default: begin
        next_seq = mifl_pkg::MIFL_SEQ_IDLE;
      end
    endcase
  end

  // flags and mask
  always_comb begin
    next_flags = flags & ~`MIFL_FLAGS_RESET; // R12
    if (rc_accept) begin
      // only the bits handed out are cleared, later events survive
      next_flags = next_flags & ~avs_readdata[`MIFL_NFLAGS-1:0]; // R4 R17
    end
    next_flags = next_flags | evt; // R1 R3
    next_mask = mask;
    if (accept & avs_write & (idx == `MIFL_IDX_MASK)) begin
      next_mask = ((mask & ~be_bits) | (avs_writedata[`MIFL_NFLAGS-1:0] & be_bits))
                  & `MIFL_MASK_WRITABLE; // R18
    end
    if (brownout_event) begin
      next_flags = `MIFL_FLAGS_RESET; // R12
      next_mask = `MIFL_MASK_RESET; // R12
    end
  end

  // bus answer, one wait cycle per access
  always_comb begin
    next_wait = ~(req & wait_q);
    next_rdata = avs_readdata;
    if (req & wait_q & avs_read) begin
      unique case (idx)
        `MIFL_IDX_MASK: next_rdata = pad(mask);
        `MIFL_IDX_STATUS: next_rdata = pad(flags);
        `MIFL_IDX_CLEAR_ON_READ: next_rdata = pad(flags);
        default: next_rdata = '0;
      endcase
    end
    next_irq_oe = pend; // R2 R19
    next_irq_n = ~pend; // R2 R19
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags <= `MIFL_FLAGS_RESET;
      mask <= `MIFL_MASK_RESET;
      seq <= mifl_pkg::MIFL_SEQ_IDLE;
      wait_q <= 1'b1;
      avs_readdata <= '0;
      irq_n_out <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      flags <= next_flags;
      mask <= next_mask;
      seq <= next_seq;
      wait_q <= next_wait;
      avs_readdata <= next_rdata;
      irq_n_out <= next_irq_n;
      irq_oe <= next_irq_oe;
    end
  end

  assign avs_waitrequest = wait_q;

  AST_EVENT_SETS: assert property (@(posedge clk_sys) disable iff (reset) // R1
    (evt != `MIFL_FLAGS_ZERO && !brownout_event) |=> ((flags & $past(evt)) == $past(evt)))
    else $error("event did not set its flag");

  AST_IRQ_LOW: assert property (@(posedge clk_sys) disable iff (reset) // R2
    ((flags & mask) != `MIFL_FLAGS_ZERO) |=> (!irq_n_out && irq_oe))
    else $error("enabled flag did not pull interrupt low");

  AST_STICKY: assert property (@(posedge clk_sys) disable iff (reset) // R3
    (!rc_accept && !brownout_event) |=>
      ((flags & $past(flags & ~`MIFL_FLAGS_RESET)) == $past(flags & ~`MIFL_FLAGS_RESET)))
    else $error("flag dropped without clear");

  AST_RC_CLEAR: assert property (@(posedge clk_sys) disable iff (reset) // R4
    (rc_accept && evt == `MIFL_FLAGS_ZERO && !brownout_event) |=>
      ((flags & $past(avs_readdata[`MIFL_NFLAGS-1:0])) == `MIFL_FLAGS_ZERO))
    else $error("clear-on-read left flags set");

  AST_ACTIVE_HALF: assert property (@(posedge clk_sys) disable iff (reset) // R6
    (lvl.chg[`MIFL_LV_ACT +: `MIFL_NPH] != '0 && !brownout_event)
      |=> flags[`MIFL_B_ACTIVE_ENERGY_HALF])
    else $error("active half flag missed");

  AST_RESET_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (reset) // R12
    (flags[`MIFL_B_RESET] && !brownout_event) |=> !flags[`MIFL_B_RESET])
    else $error("reset flag held beyond one cycle");

  AST_SIGN_SELECT: assert property (@(posedge clk_sys) disable iff (reset) // R15
    (phase_sum_select == '0 && !$past(flags[`MIFL_B_ACTIVE_POWER_SIGN])
     && !flags[`MIFL_B_ACTIVE_POWER_SIGN])
      |=> !flags[`MIFL_B_ACTIVE_POWER_SIGN])
    else $error("sign flag set for unselected phases");

  AST_SEQ_ERR: assert property (@(posedge clk_sys) disable iff (reset) // R16
    (seq == mifl_pkg::MIFL_SEQ_AFTER_A && crossing_event[`MIFL_PH_B]
     && !crossing_event[`MIFL_PH_C] && !brownout_event)
      |=> flags[`MIFL_B_PHASE_SEQUENCE_ERROR])
    else $error("phase sequence error missed");

  AST_IRQ_RELEASE: assert property (@(posedge clk_sys) disable iff (reset) // R17
    (rc_accept && evt == `MIFL_FLAGS_ZERO
     && ((flags & ~avs_readdata[`MIFL_NFLAGS-1:0] & mask) == `MIFL_FLAGS_ZERO))
      |=> ##1 (irq_n_out && !irq_oe))
    else $error("interrupt not released by clear-on-read");

  AST_MASK_RESERVED: assert property (@(posedge clk_sys) disable iff (reset) // R18
    !mask[`MIFL_B_RESET])
    else $error("reserved mask bit set");

  AST_IRQ_OR: assert property (@(posedge clk_sys) disable iff (reset) // R19
    ##1 (irq_oe == $past(|(flags & mask & `MIFL_MASK_WRITABLE))))
    else $error("interrupt not the or of enabled flags");

  AST_BUS_ANSWER: assert property (@(posedge clk_sys) disable iff (reset)
    (req && wait_q) |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");

  AST_REACT_HALF: assert property (@(posedge clk_sys) disable iff (reset) // R6
    (lvl.chg[`MIFL_LV_REACT +: `MIFL_NPH] != '0 && !brownout_event)
      |=> flags[`MIFL_B_REACTIVE_ENERGY_HALF])
    else $error("reactive half flag missed");

  AST_APP_HALF: assert property (@(posedge clk_sys) disable iff (reset) // R7
    (lvl.rise[`MIFL_LV_APP +: `MIFL_NPH] != '0 && !brownout_event)
      |=> flags[`MIFL_B_APPARENT_ENERGY_HALF])
    else $error("apparent half flag missed");

  AST_SAG_SETS: assert property (@(posedge clk_sys) disable iff (reset) // R8
    (sag_event != '0 && !brownout_event) |=>
      ((flags[`MIFL_B_SAG +: `MIFL_NPH] & $past(sag_event)) == $past(sag_event)))
    else $error("sag flag missed");

  AST_TIMEOUT_SETS: assert property (@(posedge clk_sys) disable iff (reset) // R9
    (timeout_event != '0 && !brownout_event) |=>
      ((flags[`MIFL_B_TIMEOUT +: `MIFL_NPH] & $past(timeout_event)) == $past(timeout_event)))
    else $error("crossing timeout flag missed");

  AST_CROSS_SETS: assert property (@(posedge clk_sys) disable iff (reset) // R10
    (crossing_event != '0 && !brownout_event) |=>
      ((flags[`MIFL_B_CROSS +: `MIFL_NPH] & $past(crossing_event)) == $past(crossing_event)))
    else $error("crossing flag missed");

  AST_LINE_DONE: assert property (@(posedge clk_sys) disable iff (reset) // R11
    (line_accum_done && !brownout_event) |=> flags[`MIFL_B_LINE_ACCUM_DONE])
    else $error("line accumulation flag missed");

  AST_PEAK_V: assert property (@(posedge clk_sys) disable iff (reset) // R13
    (peak_voltage_event && !brownout_event) |=> flags[`MIFL_B_PEAK_VOLTAGE])
    else $error("peak voltage flag missed");

  AST_PEAK_I: assert property (@(posedge clk_sys) disable iff (reset) // R13
    (peak_current_event && !brownout_event) |=> flags[`MIFL_B_PEAK_CURRENT])
    else $error("peak current flag missed");

  AST_WAVE: assert property (@(posedge clk_sys) disable iff (reset) // R14
    (waveform_sample_event && !brownout_event) |=> flags[`MIFL_B_WAVEFORM_SAMPLE])
    else $error("waveform sample flag missed");

  AST_SEQ_QUIET: assert property (@(posedge clk_sys) disable iff (reset) // R16
    (seq == mifl_pkg::MIFL_SEQ_IDLE && !flags[`MIFL_B_PHASE_SEQUENCE_ERROR])
      |=> !flags[`MIFL_B_PHASE_SEQUENCE_ERROR])
    else $error("sequence error without a preceding a crossing");

  AST_BROWNOUT: assert property (@(posedge clk_sys) disable iff (reset) // R12
    brownout_event |=> (flags == `MIFL_FLAGS_RESET && mask == `MIFL_MASK_RESET))
    else $error("brownout did not restore defaults");

  AST_MASK_WRITE: assert property (@(posedge clk_sys) disable iff (reset) // R18
    (accept && avs_write && idx == `MIFL_IDX_MASK && &avs_byteenable && !brownout_event) |=>
      (mask == ($past(avs_writedata[`MIFL_NFLAGS-1:0]) & `MIFL_MASK_WRITABLE)))
    else $error("mask write not applied");

  AST_RC_DATA: assert property (@(posedge clk_sys) disable iff (reset) // R4
    (req && wait_q && avs_read && idx == `MIFL_IDX_CLEAR_ON_READ) |=>
      (avs_readdata[`MIFL_NFLAGS-1:0] == $past(flags)))
    else $error("clear-on-read data not the flags");
endmodule : mifl_top

// *** mifl_top_test.sv ***
// self-checking testbench of the metering interrupt flag block
`timescale 1ns/1ps
`include "mifl_defs.svh"
`define MIFL_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module mifl_top_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] adr;
  logic rd_r, wr_r, oe, irq_n;
  logic [31:0] wd, rdata, q, st;
  logic [3:0] be;
  logic wt;
  logic [2:0] act14 = 3'b000, react14 = 3'b000, app15 = 3'b000;
  logic [2:0] psign = 3'b000, qsign = 3'b000, psel = 3'b001;
  logic [19:0] ev = 20'h0;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  initial forever #10 clk_sys = ~clk_sys;

  mifl_top mifl_top_i (.clk_sys(clk_sys), .reset(reset), .avs_address(adr),
    .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wt), .active_accum_bit14(act14),
    .reactive_accum_bit14(react14), .apparent_accum_bit15(app15),
    .sag_event(ev[5:3]), .timeout_event(ev[8:6]), .crossing_event(ev[11:9]),
    .line_accum_done(ev[12]), .peak_voltage_event(ev[14]),
    .peak_current_event(ev[15]), .waveform_sample_event(ev[16]),
    .brownout_event(ev[13]), .active_power_sign(psign),
    .reactive_power_sign(qsign), .phase_sum_select(psel),
    .irq_n_out(irq_n), .irq_oe(oe));

  mifl_host_model mifl_host_model_i (.clk_sys(clk_sys), .avs_address(adr),
    .avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wt), .irq_n_out(irq_n));

  task automatic rd(input logic [5:0] i);
    mifl_host_model_i.acc(1'b0, i, 32'h0, 4'hf, q);
  endtask : rd

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    mifl_host_model_i.acc(1'b1, i, d, 4'hf, q);
  endtask : wr

  task automatic wrb(input logic [5:0] i, input logic [31:0] d, input logic [3:0] b);
    mifl_host_model_i.acc(1'b1, i, d, b, q);
  endtask : wrb

  task automatic pulse(input logic [19:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= 20'h0;
  endtask : pulse

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : waitc

  // sticky copy, clearing copy, then empty
  task automatic flags(input logic [31:0] e);
    waitc(3);
    rd(`MIFL_IDX_STATUS);
    `MIFL_CHK(q, e)
    rd(`MIFL_IDX_CLEAR_ON_READ);
    `MIFL_CHK(q, e)
    rd(`MIFL_IDX_STATUS);
    `MIFL_CHK(q, 32'h0)
  endtask : flags

  task automatic summarize;
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(`MIFL_IDX_MASK);
    `MIFL_CHK(q, 32'h0)
    rd(`MIFL_IDX_STATUS);
    `MIFL_CHK(q, 32'h0)
    for (int b = 3; b < 17; b++) begin
      if (b inside {[3:8], 12, 14, 15, 16}) begin
        pulse(20'h1 << b);
        flags(32'h1 << b);
      end
    end
    @(posedge clk_sys);
    act14 <= 3'b100;
    flags(32'h1);
    react14 <= 3'b010;
    flags(32'h2);
    app15 <= 3'b001;
    flags(32'h4);
    app15 <= 3'b000;
    flags(32'h0);
    psign <= 3'b010;
    flags(32'h0);
    psign <= 3'b011;
    flags(32'h20000);
    qsign <= 3'b001;
    flags(32'h40000);
    psel <= 3'b000;
    psign <= 3'b000;
    flags(32'h0);
    psel <= 3'b110;
    psign <= 3'b010;
    flags(32'h20000);
    pulse(20'h00200);
    pulse(20'h00800);
    pulse(20'h00400);
    flags(32'he00);
    pulse(20'h00200);
    pulse(20'h00400);
    flags(32'h80600);
    wr(`MIFL_IDX_MASK, 32'hffffffff);
    rd(`MIFL_IDX_MASK);
    `MIFL_CHK(q, 32'h000fdfff)
    wrb(`MIFL_IDX_MASK, 32'h0, 4'h2);
    rd(`MIFL_IDX_MASK);
    `MIFL_CHK(q, 32'h000f00ff)
    wr(`MIFL_IDX_MASK, 32'h10);
    pulse(20'h8);
    waitc(3);
    `MIFL_CHK(irq_n, 1'b1)
    pulse(20'h10);
    waitc(3);
    `MIFL_CHK(irq_n, 1'b0)
    `MIFL_CHK(oe, 1'b1)
    waitc(10);
    `MIFL_CHK(irq_n, 1'b0)
    mifl_host_model_i.service(st, q);
    `MIFL_CHK(st, 32'h18)
    `MIFL_CHK(q, 32'h18)
    waitc(3);
    `MIFL_CHK(irq_n, 1'b1)
    `MIFL_CHK(oe, 1'b0)
    wr(`MIFL_IDX_STATUS, 32'hffffffff);
    rd(`MIFL_IDX_STATUS);
    `MIFL_CHK(q, 32'h0)
    rd(6'h3f);
    `MIFL_CHK(q, 32'h0)
    pulse(20'h02000);
    waitc(3);
    rd(`MIFL_IDX_MASK);
    `MIFL_CHK(q, 32'h0)
    rd(`MIFL_IDX_STATUS);
    `MIFL_CHK(q, 32'h0)
    summarize();
  end
endmodule : mifl_top_test
